// file: include/aut_pkg.sv
// Shared constants and types for the asynchronous timer update block
`default_nettype none
package aut_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] AUT_OFS_COUNT   = 8'h00;
    localparam logic [7:0] AUT_OFS_COMPARE = 8'h04;
    localparam logic [7:0] AUT_OFS_CONTROL = 8'h08;
    localparam logic [7:0] AUT_OFS_STATUS  = 8'h0C;
    localparam logic [7:0] AUT_OFS_FLAGS   = 8'h10;
    localparam logic [7:0] AUT_OFS_IRQ_EN  = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int AUT_ST_CONTROL_PEND = 0;
    localparam int AUT_ST_COMPARE_PEND = 1;
    localparam int AUT_ST_COUNT_PEND   = 2;
    localparam int AUT_ST_ASYNC_SEL    = 3;
    localparam int AUT_CTL_CS_LO       = 0;
    localparam int AUT_CTL_CS_HI       = 2;
    localparam int AUT_CTL_CLR_MATCH   = 3;
    localparam int AUT_CTL_COM_LO      = 4;
    localparam int AUT_CTL_COM_HI      = 5;
    localparam int AUT_FL_COMPARE      = 0;
    localparam int AUT_FL_OVERFLOW     = 1;

    // Holding-register slots, one per asynchronous register
    localparam int AUT_SLOT_CONTROL = 0;
    localparam int AUT_SLOT_COMPARE = 1;
    localparam int AUT_SLOT_COUNT   = 2;

    // ------------------------------------------------------------
    // Reset values and timing counts
    // ------------------------------------------------------------
    localparam logic [7:0] AUT_RST_REG8     = 8'h00;
    localparam logic [7:0] AUT_COUNT_TOP    = 8'hFF;
    localparam int         AUT_FLAG_DELAY   = 3;   // processor cycles for flag visibility

    // Compare output modes
    typedef enum logic [1:0] {
        AUT_COM_OFF    = 2'h0,
        AUT_COM_TOGGLE = 2'h1,
        AUT_COM_CLEAR  = 2'h2,
        AUT_COM_SET    = 2'h3
    } aut_com_t;

    // Classic Wishbone request and response
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } aut_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } aut_wb_rsp_t;
endpackage
`default_nettype wire

// file: logic/aut_sync.sv
// Two-stage synchroniser with rising-edge detection for an outside level
`timescale 1ns/1ps
`default_nettype none
module aut_sync #(
    parameter int STAGES = 2
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic din,
    output logic      dout,
    output logic      rise
);
    import aut_pkg::*;

    logic [STAGES-1:0] sync_q;
    logic              last_q;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (STAGES < 2) begin : g_bad
        $error("aut_sync needs at least two stages");
    end

    // Only the last stage is read; the first stage may be metastable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync_q <= '0;
            last_q <= 1'b0;
        end else if (ce) begin
            sync_q <= {sync_q[STAGES-2:0], din};
            last_q <= sync_q[STAGES-1];
        end
    end

    assign dout = sync_q[STAGES-1];
    assign rise = ce & sync_q[STAGES-1] & ~last_q;
endmodule
`default_nettype wire

// file: logic/aut_timer.sv
// Timer with holding registers and update-pending flags for slow-oscillator operation
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Async compare write sets compare pending; cleared when compare register is loaded.
// - Async control write sets control pending; cleared when control register is loaded.
// - Count reads give live count outside the post-wake hold; compare and control reads give holding registers.
// - Writes land in a holding register; async writes commit after two slow oscillator rising edges, sync writes at once.
// - Each of count, compare and control has its own holding register and pending flag.
// - No compare match while compare or count write is pending.
// - Wake logic re-arms only after one slow oscillator cycle.
// - Oscillator stops only in power-down; timer contents invalid afterwards.
// - Wake begins on the timer clock cycle after the interrupt condition.
// - Wake happens regardless of the global interrupt enable.
// - Flags become visible three processor cycles after the event.
// - Flag synchronisation takes three processor cycles after the timer tick.
// - Compare output pin changes on the timer tick, not processor synchronised.
// - After power-save wake in async mode, count reads hold pre-sleep value until first edge.
// - Hardware never changes compare or control register except to clear both in power-down.
// - Async select bit chooses slow oscillator when set, system clock when clear.
// - Async count write sets count pending; cleared when counter is loaded.
module aut_timer (
    input  wire logic                CLK_SYS,
    input  wire logic                RST_B,
    input  wire logic                CE,
    input  wire aut_pkg::aut_wb_req_t WB_REQ,
    output aut_pkg::aut_wb_rsp_t     WB_RSP,
    input  wire logic                SLOW_OSC_INPUT,
    input  wire logic                POWER_SAVE,
    input  wire logic                POWER_DOWN,
    output logic                     COMPARE_OUT,
    output logic                     COMPARE_IRQ,
    output logic                     OVERFLOW_IRQ,
    output logic                     WAKE
);
    import aut_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]  hold_q [3];          // Holding registers, one per slot
    logic [2:0]  pend_q;              // Update-pending flags
    logic [2:0]  seen_q;              // First oscillator edge seen per slot
    logic [7:0]  count_q;
    logic [7:0]  compare_q;
    logic [7:0]  control_q;
    logic        async_sel_q;
    logic [1:0]  flags_q;
    logic [1:0]  irq_en_q;
    logic [AUT_FLAG_DELAY-1:0] cmp_pipe_q;
    logic [AUT_FLAG_DELAY-1:0] ovf_pipe_q;
    logic        cmp_out_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        wake_cond_q;
    logic        armed_q;
    logic        wake_q;
    logic        stale_q;
    logic [7:0]  stale_count_q;
    logic        save_last_q;
    logic        down_last_q;

    logic        osc_level;
    logic        osc_rise;
    logic        tick;
    logic        wr;
    logic        rd;
    logic [2:0]  commit;
    logic [2:0]  hit;
    logic [7:0]  count_next;
    logic        match;
    logic        overflow;
    logic        wake_exit;

    // ------------------------------------------------------------
    // Slow oscillator sampling
    // ------------------------------------------------------------
    aut_sync #(
        .STAGES (2)
    ) u_osc_sync (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .ce    (CE),
        .din   (SLOW_OSC_INPUT),
        .dout  (osc_level),
        .rise  (osc_rise)
    );

    // Decode a register offset into its holding slot
    function automatic logic [2:0] slot_hit(input logic [7:0] adr);
        slot_hit = {adr == AUT_OFS_COUNT, adr == AUT_OFS_COMPARE, adr == AUT_OFS_CONTROL};
    endfunction

    // Slot select of the current bus address, shared by the holding path
    assign hit = slot_hit(WB_REQ.adr);

    // Bus strobes: a request is taken in the cycle ack is raised
    assign wr = CE & WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & WB_REQ.sel[0] & ~ack_q;
    assign rd = CE & WB_REQ.cyc & WB_REQ.stb & ~WB_REQ.we & ~ack_q;

    // Counter clock: oscillator edge when async, every enabled cycle otherwise
    assign tick = (async_sel_q ? osc_rise : CE) & (control_q[AUT_CTL_CS_HI:AUT_CTL_CS_LO] != 3'h0);

    // Commit on the second rising oscillator edge after the write
    assign commit = {3{osc_rise}} & pend_q & seen_q;

    // ------------------------------------------------------------
    // Counter, match and overflow
    // ------------------------------------------------------------
    assign count_next = (count_q == AUT_COUNT_TOP) ? AUT_RST_REG8 : count_q + 8'h01;
    assign match    = tick & (count_next == compare_q)
                      & ~pend_q[AUT_SLOT_COMPARE] & ~pend_q[AUT_SLOT_COUNT];
    assign overflow = tick & (count_q == AUT_COUNT_TOP);

    // Bus write and transfer of the compare and control holding registers into the live registers
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            for (int i = 0; i < 3; i++) begin
                hold_q[i] <= AUT_RST_REG8;
            end
            pend_q    <= 3'h0;
            seen_q    <= 3'h0;
            compare_q <= AUT_RST_REG8;
            control_q <= AUT_RST_REG8;
        end else if (CE) begin
            if (POWER_DOWN) begin
                // Oscillator is stopped; contents are lost across power-down
                for (int i = 0; i < 3; i++) begin
                    hold_q[i] <= AUT_RST_REG8;
                end
                pend_q    <= 3'h0;
                seen_q    <= 3'h0;
                compare_q <= AUT_RST_REG8;
                control_q <= AUT_RST_REG8;
            end else begin
                for (int i = 0; i < 3; i++) begin
                    if (wr && hit[i]) begin
                        hold_q[i] <= WB_REQ.dat[7:0];
                        pend_q[i] <= async_sel_q;
                        seen_q[i] <= 1'b0;
                    end else if (commit[i]) begin
                        pend_q[i] <= 1'b0;
                        seen_q[i] <= 1'b0;
                    end else if (osc_rise && pend_q[i]) begin
                        seen_q[i] <= 1'b1;
                    end
                end
                // Only software writes reach these: directly in sync mode, through the holding path in async mode
                if (wr && WB_REQ.adr == AUT_OFS_COMPARE && !async_sel_q) begin
                    compare_q <= WB_REQ.dat[7:0];
                end else if (commit[AUT_SLOT_COMPARE]) begin
                    compare_q <= hold_q[AUT_SLOT_COMPARE];
                end
                if (wr && WB_REQ.adr == AUT_OFS_CONTROL && !async_sel_q) begin
                    control_q <= WB_REQ.dat[7:0];
                end else if (commit[AUT_SLOT_CONTROL]) begin
                    control_q <= hold_q[AUT_SLOT_CONTROL];
                end
            end
        end
    end

    // Live counter; a committed load replaces the increment on that tick
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            count_q <= AUT_RST_REG8;
        end else if (CE) begin
            if (POWER_DOWN) begin
                count_q <= AUT_RST_REG8;
            end else if (wr && WB_REQ.adr == AUT_OFS_COUNT && !async_sel_q) begin
                count_q <= WB_REQ.dat[7:0];
            end else if (commit[AUT_SLOT_COUNT]) begin
                count_q <= hold_q[AUT_SLOT_COUNT];
            end else if (match && control_q[AUT_CTL_CLR_MATCH]) begin
                count_q <= AUT_RST_REG8;
            end else if (tick) begin
                count_q <= count_next;
            end
        end
    end

    // Async select bit; the pending bits are not writable
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            async_sel_q <= 1'b0;
        end else if (CE && wr && WB_REQ.adr == AUT_OFS_STATUS) begin
            async_sel_q <= WB_REQ.dat[AUT_ST_ASYNC_SEL];
        end
    end

    // ------------------------------------------------------------
    // Compare output pin
    // ------------------------------------------------------------
    // Driven straight from the timer tick so it follows the timer clock
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cmp_out_q <= 1'b0;
        end else if (CE && POWER_DOWN) begin
            cmp_out_q <= 1'b0;
        end else if (CE && match) begin
            case (aut_com_t'(control_q[AUT_CTL_COM_HI:AUT_CTL_COM_LO]))
                AUT_COM_TOGGLE: cmp_out_q <= ~cmp_out_q;
                AUT_COM_CLEAR:  cmp_out_q <= 1'b0;
                AUT_COM_SET:    cmp_out_q <= 1'b1;
                default:        cmp_out_q <= cmp_out_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Flag synchronisation and sticky flags
    // ------------------------------------------------------------
    // Events arise on a timer tick, then wait three processor cycles
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            cmp_pipe_q <= '0;
            ovf_pipe_q <= '0;
        end else if (CE && POWER_DOWN) begin
            // Events in flight are dropped with the rest of the timer state
            cmp_pipe_q <= '0;
            ovf_pipe_q <= '0;
        end else if (CE) begin
            cmp_pipe_q <= {cmp_pipe_q[AUT_FLAG_DELAY-2:0], match};
            ovf_pipe_q <= {ovf_pipe_q[AUT_FLAG_DELAY-2:0], overflow};
        end
    end

    // Write one to clear; a new event in the same cycle wins
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            flags_q <= 2'h0;
        end else if (CE && POWER_DOWN) begin
            flags_q <= 2'h0;
        end else if (CE) begin
            if (wr && WB_REQ.adr == AUT_OFS_FLAGS) begin
                flags_q <= flags_q & ~WB_REQ.dat[1:0];
            end
            if (cmp_pipe_q[AUT_FLAG_DELAY-1]) begin
                flags_q[AUT_FL_COMPARE] <= 1'b1;
            end
            if (ovf_pipe_q[AUT_FLAG_DELAY-1]) begin
                flags_q[AUT_FL_OVERFLOW] <= 1'b1;
            end
        end
    end

    // Interrupt enables
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            irq_en_q <= 2'h0;
        end else if (CE && wr && WB_REQ.adr == AUT_OFS_IRQ_EN) begin
            irq_en_q <= WB_REQ.dat[1:0];
        end
    end

    // ------------------------------------------------------------
    // Wake from power-save
    // ------------------------------------------------------------
    // Condition is latched, the wake itself waits for the next oscillator rising edge.
    // Global interrupt enable is deliberately not consulted here.
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            wake_cond_q <= 1'b0;
            wake_q      <= 1'b0;
            armed_q     <= 1'b1;
        end else if (CE) begin
            if (POWER_SAVE && armed_q && (
                    (match && irq_en_q[AUT_FL_COMPARE]) ||
                    (overflow && irq_en_q[AUT_FL_OVERFLOW]))) begin
                wake_cond_q <= 1'b1;
            end else if (osc_rise) begin
                wake_cond_q <= 1'b0;
            end
            wake_q <= wake_cond_q & osc_rise;
            if (wake_q) begin
                armed_q <= 1'b0;
            end else if (osc_rise) begin
                armed_q <= 1'b1;
            end
        end
    end

    // Track leaving power-save to hold the old count until an edge
    assign wake_exit = save_last_q & ~POWER_SAVE;
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            save_last_q   <= 1'b0;
            down_last_q   <= 1'b0;
            stale_q       <= 1'b0;
            stale_count_q <= AUT_RST_REG8;
        end else if (CE) begin
            save_last_q <= POWER_SAVE;
            down_last_q <= POWER_DOWN;
            if (POWER_SAVE && !save_last_q) begin
                stale_count_q <= count_q;
            end
            if (wake_exit && async_sel_q) begin
                stale_q <= 1'b1;
            end else if (osc_rise) begin
                stale_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Wishbone slave: ack one cycle after the strobe, zero off-map
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else if (CE) begin
            ack_q <= WB_REQ.cyc & WB_REQ.stb & ~ack_q;
            if (rd) begin
                case (WB_REQ.adr)
                    AUT_OFS_COUNT:   rdat_q <= {24'h000000, stale_q ? stale_count_q : count_q};
                    AUT_OFS_COMPARE: rdat_q <= {24'h000000, hold_q[AUT_SLOT_COMPARE]};
                    AUT_OFS_CONTROL: rdat_q <= {24'h000000, hold_q[AUT_SLOT_CONTROL]};
                    AUT_OFS_STATUS:  rdat_q <= {28'h0000000, async_sel_q, pend_q[2:0]};
                    AUT_OFS_FLAGS:   rdat_q <= {30'h0, flags_q};
                    AUT_OFS_IRQ_EN:  rdat_q <= {30'h0, irq_en_q};
                    default:         rdat_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign WB_RSP.ack   = ack_q;
    assign WB_RSP.dat   = rdat_q;
    assign COMPARE_OUT  = cmp_out_q;
    assign COMPARE_IRQ  = flags_q[AUT_FL_COMPARE] & irq_en_q[AUT_FL_COMPARE];
    assign OVERFLOW_IRQ = flags_q[AUT_FL_OVERFLOW] & irq_en_q[AUT_FL_OVERFLOW];
    assign WAKE         = wake_q;
endmodule
`default_nettype wire

// file: bench/aut_timer_assertions.sv
// Checker of bus, wake, flag and output timing at the timer ports
`timescale 1ns/1ps
`default_nettype none
module aut_timer_assertions (
    input wire logic                 CLK_SYS,
    input wire logic                 RST_B,
    input wire logic                 CE,
    input wire aut_pkg::aut_wb_req_t WB_REQ,
    input wire aut_pkg::aut_wb_rsp_t WB_RSP,
    input wire logic                 SLOW_OSC_INPUT,
    input wire logic                 POWER_SAVE,
    input wire logic                 POWER_DOWN,
    input wire logic                 COMPARE_OUT,
    input wire logic                 COMPARE_IRQ,
    input wire logic                 OVERFLOW_IRQ,
    input wire logic                 WAKE
);
    import aut_pkg::*;
    logic       take;
    logic       async_q;
    logic       osc_q;
    logic [3:0] age_q;
    assign take = CE && WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
    // Mirror of the async select bit, so sync-mode activity is not judged by link timing
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) async_q <= 1'b0;
        else if (take && WB_REQ.we && WB_REQ.sel[0] && WB_REQ.adr == AUT_OFS_STATUS)
            async_q <= WB_REQ.dat[AUT_ST_ASYNC_SEL];
    end
    // Cycles since the pin was first seen high; saturates so it never wraps
    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            osc_q <= 1'b0;
            age_q <= 4'hF;
        end else begin
            osc_q <= SLOW_OSC_INPUT;
            if (SLOW_OSC_INPUT && !osc_q) age_q <= 4'h0;
            else if (age_q != 4'hF) age_q <= age_q + 4'h1;
        end
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    AST_ACK_ONE : assert property (take |=> WB_RSP.ack)
        else $error("ack missing one cycle after request");
    AST_ACK_DROP : assert property (WB_RSP.ack && CE |=> !WB_RSP.ack)
        else $error("ack held longer than one cycle");
    AST_WAKE_GAP : assert property (WAKE |=> !WAKE [*4])
        else $error("wake repeated before re-arm");
    AST_WAKE_SAVE : assert property ($rose(WAKE) |-> $past(POWER_SAVE))
        else $error("wake outside power-save");
    AST_WAKE_EDGE : assert property (WAKE |-> age_q inside {[1:5]})
        else $error("wake not tied to an oscillator edge");
    AST_FLAG_DELAY : assert property (($rose(COMPARE_IRQ) || $rose(OVERFLOW_IRQ))
        && async_q && !WB_RSP.ack |-> age_q inside {[3:7]})
        else $error("flag visible at wrong delay after tick");
    AST_OUT_TICK : assert property ($changed(COMPARE_OUT) && async_q && $past(async_q)
        && !POWER_DOWN && !$past(POWER_DOWN) |-> age_q inside {[1:4]})
        else $error("compare output moved away from a timer tick");
    AST_PD_CLEAR : assert property (POWER_DOWN |=> !COMPARE_OUT && !COMPARE_IRQ
        && !OVERFLOW_IRQ)
        else $error("timer state kept in power-down");
    cover property ($rose(WAKE));
    cover property ($rose(COMPARE_IRQ));
    cover property ($changed(COMPARE_OUT));
endmodule
`default_nettype wire

// file: bench/aut_wb_master.sv
// Classic Wishbone master standing in for the processor side
`timescale 1ns/1ps
`default_nettype none
module aut_wb_master (
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 go,
    input  wire logic                 we,
    input  wire logic [7:0]           adr,
    input  wire logic [7:0]           wdat,
    input  wire aut_pkg::aut_wb_rsp_t rsp,
    output aut_pkg::aut_wb_req_t      req,
    output logic                      done,
    output logic [31:0]               rdat
);
    import aut_pkg::*;
    // Done blocks a restart, so cyc rests at least one cycle between requests
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            req  <= '0;
            done <= 1'b0;
            rdat <= 32'h0;
        end else if (req.cyc && rsp.ack) begin
            // Released we, adr and dat show the inverse so stale values never look valid
            req  <= '{1'b0, 1'b0, ~req.we, ~req.adr, req.sel, ~req.dat};
            done <= 1'b1;
            rdat <= rsp.dat;
        end else if (go && !req.cyc && !done) begin
            req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, wdat}};
        end else begin
            done <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: bench/aut_timer_test.sv
// Self-checking bench for the asynchronous timer update block
`timescale 1ns/1ps
`default_nettype none
module aut_timer_test;
    import aut_pkg::*;
    logic        clk_sys, rst_b, ce, osc, p_save, p_down, go, we, done;
    logic        cmp_out, cmp_irq, ovf_irq, wake;
    logic [7:0]  adr, wdat, rd;
    logic [31:0] rdat;
    logic [1:0]  div;
    int          n_fail, n_checks, el;
    aut_wb_req_t req;
    aut_wb_rsp_t rsp;
    aut_timer u_aut_timer (.CLK_SYS(clk_sys), .RST_B(rst_b), .CE(ce), .WB_REQ(req),
        .WB_RSP(rsp), .SLOW_OSC_INPUT(osc), .POWER_SAVE(p_save), .POWER_DOWN(p_down),
        .COMPARE_OUT(cmp_out), .COMPARE_IRQ(cmp_irq), .OVERFLOW_IRQ(ovf_irq), .WAKE(wake));
    aut_wb_master u_aut_wb_master (.clk_sys(clk_sys), .rst_b(rst_b), .go(go), .we(we),
        .adr(adr), .wdat(wdat), .rsp(rsp), .req(req), .done(done), .rdat(rdat));
    // ----------------------------------------------------------------
    // Clock, free-running 400 ns oscillator, watchdog
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        div <= div + 2'h1;
        if (div == 2'h3) osc <= ~osc;
    end
    initial begin
        #1000000;
        n_fail++;
        end_of_test();
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus cycle through the master model; waits for its done under a bound
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int t;
        @(posedge clk_sys);
        go <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        t = 0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (done !== 1'b1 && t < 20);
        go <= 1'b0;
        rd = rdat[7:0];
        if (t >= 20) chk("bus answer", 8'h1, 8'h0);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        chk(what, exp, rd);
    endtask
    // Poll status until no update is pending; el counts elapsed cycles
    task automatic wait_idle();
        el = 0;
        do begin
            bus(1'b0, AUT_OFS_STATUS, 8'h00);
            el += 5;
        end while (rd[2:0] !== 3'h0 && el < 100);
    endtask
    task automatic wait_sig(ref logic s, input string what);
        int t;
        t = 0;
        while (s !== 1'b1 && t < 900) begin
            @(posedge clk_sys);
            t++;
        end
        chk(what, 8'h1, {7'h0, s});
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdchk(AUT_OFS_COUNT, AUT_RST_REG8, "count reset");
        rdchk(AUT_OFS_COMPARE, AUT_RST_REG8, "compare reset");
        rdchk(AUT_OFS_CONTROL, AUT_RST_REG8, "control reset");
        rdchk(8'h18, 8'h00, "unmapped read");
        bus(1'b1, AUT_OFS_STATUS, 8'h07);
        rdchk(AUT_OFS_STATUS, 8'h00, "pending bits after write");
        bus(1'b1, AUT_OFS_COMPARE, 8'h55);
        rdchk(AUT_OFS_STATUS, 8'h00, "sync mode pending");
        rdchk(AUT_OFS_COMPARE, 8'h55, "sync compare");
    endtask
    // Safe switch to the oscillator, with writes to all three registers; only control and count overlap
    task automatic t_async();
        bus(1'b1, AUT_OFS_IRQ_EN, 8'h00);
        bus(1'b1, AUT_OFS_STATUS, 8'h08);
        bus(1'b1, AUT_OFS_COMPARE, 8'h33);
        rdchk(AUT_OFS_STATUS, 8'h0A, "compare pending");
        bus(1'b1, AUT_OFS_CONTROL, 8'h19);
        // Compare has landed by now; control alone is still waiting
        rdchk(AUT_OFS_STATUS, 8'h09, "control pending");
        bus(1'b1, AUT_OFS_COUNT, 8'h20);
        rdchk(AUT_OFS_STATUS, 8'h0D, "count pending");
        wait_idle();
        chk("commit within two edges", 8'h1, {7'h0, el >= 6 && el <= 15});
        rdchk(AUT_OFS_COMPARE, 8'h33, "compare holding");
        rdchk(AUT_OFS_CONTROL, 8'h19, "control holding");
        bus(1'b1, AUT_OFS_FLAGS, 8'h03);
        bus(1'b1, AUT_OFS_IRQ_EN, 8'h01);
        wait_sig(cmp_irq, "compare irq");
        chk("compare output toggled", 8'h1, {7'h0, cmp_out});
        rdchk(AUT_OFS_FLAGS, 8'h01, "compare flag");
        rdchk(AUT_OFS_CONTROL, 8'h19, "control kept");
        rdchk(AUT_OFS_COMPARE, 8'h33, "compare kept");
        bus(1'b1, AUT_OFS_FLAGS, 8'h01);
        chk("compare irq cleared", 8'h0, {7'h0, cmp_irq});
    endtask
    // Sleep only with nothing pending, so the match can still wake the device
    task automatic t_wake();
        logic [7:0] pre;
        wait_idle();
        p_save <= 1'b1;
        // Count as it stood on entry, read before the next oscillator tick
        bus(1'b0, AUT_OFS_COUNT, 8'h00);
        pre = rd;
        wait_sig(wake, "wake pulse");
        p_save <= 1'b0;
        rdchk(AUT_OFS_COUNT, pre, "count held after wake");
    endtask
    task automatic t_pdown();
        p_down <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("output in power-down", 8'h0, {7'h0, cmp_out});
        p_down <= 1'b0;
        rdchk(AUT_OFS_COMPARE, 8'h00, "compare after power-down");
        // Clock source choice survives power-down; pendings do not
        rdchk(AUT_OFS_STATUS, 8'h08, "status after power-down");
    endtask
    initial begin
        {rst_b, osc, p_save, p_down, go, we, div} = '0;
        {adr, wdat, n_fail, n_checks} = '0;
        ce = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_reset();
        t_async();
        t_wake();
        t_pdown();
        end_of_test();
    end
endmodule
bind aut_timer aut_timer_assertions u_aut_timer_assertions (.CLK_SYS(CLK_SYS),
    .RST_B(RST_B), .CE(CE), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP),
    .SLOW_OSC_INPUT(SLOW_OSC_INPUT), .POWER_SAVE(POWER_SAVE), .POWER_DOWN(POWER_DOWN),
    .COMPARE_OUT(COMPARE_OUT), .COMPARE_IRQ(COMPARE_IRQ), .OVERFLOW_IRQ(OVERFLOW_IRQ),
    .WAKE(WAKE));
`default_nettype wire
